// *** include/ucs_pkg.sv ***
// Purpose: Shared constants and carrier types for the serial port control block.
// Assumes: AXI4-Lite with 32-bit data and an 8-bit byte address.
// Notes:   Control bits live at fixed positions of two 8-bit registers.
package ucs_pkg;

  localparam int ADDR_W = 8;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] RCV_CTRL_STATUS_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] XMT_CTRL_STATUS_ADDR = 8'h98;
  localparam logic [ADDR_W-1:0] BAUD_DIVISOR_ADDR    = 8'h20;

  // Transmit control/status fields.
  localparam int CLOCK_SOURCE_SELECT_BIT      = 7;
  localparam int TRANSMIT_NINE_BIT_SELECT_BIT = 6;
  localparam int TRANSMIT_ENABLE_BIT          = 5;
  localparam int MODE_SELECT_BIT              = 4;
  localparam int BAUD_SPEED_SELECT_BIT        = 2;
  localparam int SHIFT_REGISTER_EMPTY_BIT     = 1;
  localparam int TRANSMIT_NINTH_DATA_BIT      = 0;

  // Receive control/status fields.
  localparam int SERIAL_PORT_ENABLE_BIT        = 7;
  localparam int RECEIVE_NINE_BIT_SELECT_BIT   = 6;
  localparam int SINGLE_RECEIVE_ENABLE_BIT     = 5;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int FRAMING_ERROR_FLAG_BIT        = 2;
  localparam int OVERRUN_ERROR_FLAG_BIT        = 1;
  localparam int RECEIVED_NINTH_DATA_BIT       = 0;

  // Software-writable bits; bit 3 and status bits are never written.
  localparam logic [7:0] XMT_WRITE_MASK = 8'hf5;
  localparam logic [7:0] RCV_WRITE_MASK = 8'hf0;
  localparam logic [7:0] XMT_RESET      = 8'h02;
  localparam logic [7:0] RCV_RESET      = 8'h00;
  localparam logic [7:0] DIVISOR_RESET  = 8'h00;

  // Clocks per divisor step for each speed.
  localparam logic [6:0] ASYNC_HIGH_PRESCALE = 7'h10;
  localparam logic [6:0] ASYNC_LOW_PRESCALE  = 7'h40;
  localparam logic [6:0] SYNC_PRESCALE       = 7'h04;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UCS_MODE_ASYNC       = 2'b00,
    UCS_MODE_SYNC_MASTER = 2'b01,
    UCS_MODE_SYNC_SLAVE  = 2'b10
  } ucs_mode_type;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } ucs_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ucs_axi_rsp_type;

  // Status reported by the transmit and receive datapaths.
  typedef struct packed {
    logic tsr_empty;
    logic rx_done;
    logic rx_ninth;
    logic rx_framing;
    logic rx_buffer_read;
  } ucs_dp_type;

  // Steering delivered to the datapaths and pin logic.
  typedef struct packed {
    ucs_mode_type mode;
    logic         pins_serial;
    logic         tx_enable;
    logic         tx_nine;
    logic         tx_ninth_data;
    logic         rx_enable;
    logic         rx_nine;
    logic         baud_tick;
  } ucs_ctrl_type;

endpackage

// *** design/ucs_top.sv ***
// Purpose: Control and status registers of a serial transmitter-receiver.
// Assumes: Datapath strobes are one-cycle pulses synchronous to aclk.
// Notes:   Contract
// Contract
// - Three modes: async, sync master, sync slave.
// - Pins serial only with enable and directions.
// - Clock source picks master or slave.
// - Transmit nine-bit select sets frame width.
// - Transmit enable; receive enables override in sync.
// - Mode select bit: sync or async.
// - Bit 3 of both registers reads zero.
// - Speed select picks async baud rate.
// - Shift register empty status, reset one.
// - Transmit ninth data bit is sent.
// - Port enable assigns pins to port.
// - Receive nine-bit select sets frame width.
// - Single receive in master, self-clearing.
// - Continuous receive, overrides single receive.
// - Framing error updated on next byte.
// - Overrun cleared only by clearing continuous receive.
// - Received ninth bit holds last frame's.
// - High speed baud is clock/(16(divisor+1)).
`timescale 1ns/1ps
`default_nettype none

module ucs_top #(
  parameter int DIV_WIDTH = 8
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire ucs_pkg::ucs_axi_req_type axi_req,
  output var  ucs_pkg::ucs_axi_rsp_type axi_rsp,
  input  wire logic [7:0]               pin_direction_control,
  input  wire ucs_pkg::ucs_dp_type      dp,
  output var  ucs_pkg::ucs_ctrl_type    ctrl
);
  import ucs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  if (DIV_WIDTH < 1 || DIV_WIDTH > 8) begin : g_bad_width
    $error("DIV_WIDTH must lie between 1 and 8");
  end

  typedef struct packed {
    logic                 aw_full;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_full;
    logic [7:0]           w_data;
    logic                 w_lane0;
    logic                 buf_full;
    logic [6:0]           pre_cnt;
    logic [DIV_WIDTH-1:0] div_cnt;
    logic [7:0]           xmt;
    logic [7:0]           rcv;
    logic [DIV_WIDTH-1:0] divisor;
    ucs_axi_rsp_type      rsp;
    ucs_ctrl_type         ctl;
  } ucs_state_type;

  localparam ucs_state_type STATE_RESET = '{
    aw_full: 1'b0, aw_addr: '0, w_full: 1'b0, w_data: 8'h00, w_lane0: 1'b0,
    buf_full: 1'b0, pre_cnt: 7'h00, div_cnt: '0,
    xmt: XMT_RESET, rcv: RCV_RESET, divisor: DIV_WIDTH'(DIVISOR_RESET),
    rsp: '0, ctl: '{mode: UCS_MODE_ASYNC, default: 1'b0}};

  ucs_state_type st_reg;
  ucs_state_type st_next;
  logic          wr_fire;
  logic          rx_take;
  logic [6:0]    prescale;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [7:0] rd;
    logic       hit;
    logic       sync_mode;
    logic       cont_rx;
    logic       single_rx;
    rd        = 8'h00;
    hit       = 1'b0;
    st_next   = st_reg;
    wr_fire   = 1'b0;
    rx_take   = 1'b0;
    prescale  = 7'h00;
    sync_mode = 1'b0;
    cont_rx   = 1'b0;
    single_rx = 1'b0;

    // Write address and data are taken independently, in either order.
    if (axi_req.awvalid && st_reg.rsp.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_reg.rsp.wready) begin
      st_next.w_full  = 1'b1;
      st_next.w_data  = axi_req.wdata[7:0];
      st_next.w_lane0 = axi_req.wstrb[0];
    end
    if (st_reg.rsp.bvalid && axi_req.bready) begin
      st_next.rsp.bvalid = 1'b0;
    end
    if (st_reg.aw_full && st_reg.w_full && !st_reg.rsp.bvalid) begin
      wr_fire            = 1'b1;
      st_next.aw_full    = 1'b0;
      st_next.w_full     = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp  = RESP_OKAY;
      case (st_reg.aw_addr)
        XMT_CTRL_STATUS_ADDR: begin
          if (st_reg.w_lane0) begin
            st_next.xmt = (st_reg.xmt & ~XMT_WRITE_MASK) |
                          (st_reg.w_data & XMT_WRITE_MASK);
          end
        end
        RCV_CTRL_STATUS_ADDR: begin
          if (st_reg.w_lane0) begin
            st_next.rcv = (st_reg.rcv & ~RCV_WRITE_MASK) |
                          (st_reg.w_data & RCV_WRITE_MASK);
            if (!st_reg.w_data[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
              st_next.rcv[OVERRUN_ERROR_FLAG_BIT] = 1'b0;
            end
          end
        end
        BAUD_DIVISOR_ADDR: begin
          if (st_reg.w_lane0) begin
            st_next.divisor = st_reg.w_data[DIV_WIDTH-1:0];
            // Restart the timer so a new rate takes effect without waiting.
            st_next.pre_cnt = 7'h00;
            st_next.div_cnt = '0;
          end
        end
        default: begin
          st_next.rsp.bresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.rsp.awready = !st_next.aw_full && !st_next.rsp.bvalid;
    st_next.rsp.wready  = !st_next.w_full && !st_next.rsp.bvalid;

    // Reads answer one cycle after the address is taken.
    if (st_reg.rsp.rvalid && axi_req.rready) begin
      st_next.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_reg.rsp.arready) begin
      hit = 1'b1;
      case (axi_req.araddr)
        XMT_CTRL_STATUS_ADDR: rd = st_reg.xmt;
        RCV_CTRL_STATUS_ADDR: rd = st_reg.rcv;
        BAUD_DIVISOR_ADDR:    rd = 8'(st_reg.divisor);
        default:              hit = 1'b0;
      endcase
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rdata  = {24'h000000, rd};
      st_next.rsp.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
    end
    st_next.rsp.arready = !st_next.rsp.rvalid;

    // Transmit shift register status follows the datapath.
    st_next.xmt[SHIFT_REGISTER_EMPTY_BIT] = dp.tsr_empty;

    // Receive buffer bookkeeping; a frame landing on a full buffer overruns under continuous receive.
    if (dp.rx_buffer_read) begin
      st_next.buf_full = 1'b0;
    end
    if (dp.rx_done && st_reg.ctl.rx_enable) begin
      if (st_reg.buf_full && !dp.rx_buffer_read) begin
        if (st_reg.rcv[CONTINUOUS_RECEIVE_ENABLE_BIT]) begin
          st_next.rcv[OVERRUN_ERROR_FLAG_BIT] = 1'b1;
        end
      end else begin
        rx_take = 1'b1;
        st_next.buf_full = 1'b1;
        st_next.rcv[FRAMING_ERROR_FLAG_BIT] = dp.rx_framing;
        if (st_reg.rcv[RECEIVE_NINE_BIT_SELECT_BIT]) begin
          st_next.rcv[RECEIVED_NINTH_DATA_BIT] = dp.rx_ninth;
        end
      end
      // A completed single reception ends itself; a new write still wins.
      if (st_reg.ctl.mode == UCS_MODE_SYNC_MASTER && !wr_fire) begin
        st_next.rcv[SINGLE_RECEIVE_ENABLE_BIT] = 1'b0;
      end
    end
    st_next.xmt[3] = 1'b0;
    st_next.rcv[3] = 1'b0;

    // Mode decode from the next register values.
    sync_mode = st_next.xmt[MODE_SELECT_BIT];
    if (!sync_mode) begin
      st_next.ctl.mode = UCS_MODE_ASYNC;
    end else if (st_next.xmt[CLOCK_SOURCE_SELECT_BIT]) begin
      st_next.ctl.mode = UCS_MODE_SYNC_MASTER;
    end else begin
      st_next.ctl.mode = UCS_MODE_SYNC_SLAVE;
    end
    cont_rx   = st_next.rcv[CONTINUOUS_RECEIVE_ENABLE_BIT];
    single_rx = st_next.rcv[SINGLE_RECEIVE_ENABLE_BIT] &&
                st_next.ctl.mode == UCS_MODE_SYNC_MASTER;
    st_next.ctl.pins_serial = st_next.rcv[SERIAL_PORT_ENABLE_BIT] &&
                              pin_direction_control[7] && pin_direction_control[6];
    st_next.ctl.rx_enable = st_next.rcv[SERIAL_PORT_ENABLE_BIT] &&
                            (cont_rx || single_rx);
    st_next.ctl.tx_enable = st_next.rcv[SERIAL_PORT_ENABLE_BIT] &&
                            st_next.xmt[TRANSMIT_ENABLE_BIT] &&
                            !(sync_mode && (cont_rx || st_next.rcv[SINGLE_RECEIVE_ENABLE_BIT]));
    st_next.ctl.tx_nine       = st_next.xmt[TRANSMIT_NINE_BIT_SELECT_BIT];
    st_next.ctl.tx_ninth_data = st_next.xmt[TRANSMIT_NINTH_DATA_BIT];
    st_next.ctl.rx_nine       = st_next.rcv[RECEIVE_NINE_BIT_SELECT_BIT];

    // Baud timer; a slave is clocked from outside and gets no tick.
    case (st_reg.ctl.mode)
      UCS_MODE_ASYNC:       prescale = st_reg.xmt[BAUD_SPEED_SELECT_BIT] ?
                                       ASYNC_HIGH_PRESCALE : ASYNC_LOW_PRESCALE;
      UCS_MODE_SYNC_MASTER: prescale = SYNC_PRESCALE;
      default:              prescale = 7'h00;
    endcase
    st_next.ctl.baud_tick = 1'b0;
    if (prescale == 7'h00 || !st_reg.rcv[SERIAL_PORT_ENABLE_BIT]) begin
      st_next.pre_cnt = 7'h00;
      st_next.div_cnt = '0;
    end else if (!(wr_fire && st_reg.aw_addr == BAUD_DIVISOR_ADDR && st_reg.w_lane0)) begin
      if (st_reg.pre_cnt >= prescale - 7'h01) begin
        st_next.pre_cnt = 7'h00;
        if (st_reg.div_cnt >= st_reg.divisor) begin
          st_next.div_cnt       = '0;
          st_next.ctl.baud_tick = 1'b1;
        end else begin
          st_next.div_cnt = st_reg.div_cnt + 1'b1;
        end
      end else begin
        st_next.pre_cnt = st_reg.pre_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign axi_rsp = st_reg.rsp;
  assign ctrl    = st_reg.ctl;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The divisor register can use all eight bits, so every read except of the divisor is watched.
  reserved_zero_a: assert property (
    axi_req.arvalid && st_reg.rsp.arready && axi_req.araddr != BAUD_DIVISOR_ADDR
    |=> !st_reg.rsp.rdata[3])
    else $error("Reserved bit 3 read back as one.");
  shift_empty_a: assert property (dp.tsr_empty |=> st_reg.xmt[SHIFT_REGISTER_EMPTY_BIT])
    else $error("Shift register empty status missed the datapath.");
  tx_override_a: assert property (
    st_reg.xmt[MODE_SELECT_BIT] && st_reg.rcv[CONTINUOUS_RECEIVE_ENABLE_BIT] |-> !ctrl.tx_enable)
    else $error("Transmitter enabled while receiving in sync mode.");
  pin_owner_a: assert property (ctrl.pins_serial |-> st_reg.rcv[SERIAL_PORT_ENABLE_BIT])
    else $error("Pins given to the port while it is disabled.");
  // An overrun in the very cycle of the clearing write wins, so that cycle is left out.
  overrun_clear_a: assert property (
    wr_fire && st_reg.aw_addr == RCV_CTRL_STATUS_ADDR && st_reg.w_lane0 &&
    !st_reg.w_data[CONTINUOUS_RECEIVE_ENABLE_BIT] && !dp.rx_done
    |=> !st_reg.rcv[OVERRUN_ERROR_FLAG_BIT])
    else $error("Overrun flag not cleared with continuous receive.");
  ninth_bit_a: assert property (
    rx_take && st_reg.rcv[RECEIVE_NINE_BIT_SELECT_BIT]
    |=> st_reg.rcv[RECEIVED_NINTH_DATA_BIT] == $past(dp.rx_ninth))
    else $error("Received ninth bit not captured.");
  frame_error_a: assert property (
    rx_take |=> st_reg.rcv[FRAMING_ERROR_FLAG_BIT] == $past(dp.rx_framing))
    else $error("Framing error flag not updated with the frame.");
  single_done_a: assert property (
    dp.rx_done && ctrl.rx_enable && ctrl.mode == UCS_MODE_SYNC_MASTER && !wr_fire
    |=> !st_reg.rcv[SINGLE_RECEIVE_ENABLE_BIT])
    else $error("Single receive enable not cleared after reception.");
  // Two quiet cycles let a prescaler left high by a slower speed wrap first.
  high_speed_a: assert property (
    ctrl.baud_tick && ctrl.mode == UCS_MODE_ASYNC && st_reg.xmt[BAUD_SPEED_SELECT_BIT] &&
    $stable(st_reg.xmt) && $past(st_reg.xmt, 2) == st_reg.xmt
    |-> $past(st_reg.pre_cnt) == 7'h0f)
    else $error("High speed tick not on the sixteenth prescale step.");
  tick_gap_a: assert property (ctrl.baud_tick |=> !ctrl.baud_tick [*3])
    else $error("Baud ticks closer than four cycles.");
  write_resp_a: assert property (
    st_reg.aw_full && st_reg.w_full && !st_reg.rsp.bvalid |=> st_reg.rsp.bvalid)
    else $error("Write response not raised after address and data.");

endmodule

`default_nettype wire

// *** test/ucs_datapath_model.sv ***
// Purpose: Stand-in for the transmit and receive datapaths beside the control block.
// Assumes: The bench requests frames, buffer reads and shift-register state through cmd.
// Notes:   Each request reaches dp one edge after the bench presents it.
`timescale 1ns/1ps
`default_nettype none
module ucs_datapath_model
  import ucs_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire ucs_pkg::ucs_dp_type cmd,
  output var  ucs_pkg::ucs_dp_type dp
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dp <= '{tsr_empty: 1'b1, default: 1'b0};
    end else begin
      dp.tsr_empty      <= cmd.tsr_empty;
      dp.rx_done        <= cmd.rx_done;
      dp.rx_buffer_read <= cmd.rx_buffer_read;
      // Outside a frame the sideband bits toggle, so stale values cannot be mistaken for data.
      dp.rx_ninth   <= cmd.rx_done ? cmd.rx_ninth : ~dp.rx_ninth;
      dp.rx_framing <= cmd.rx_done ? cmd.rx_framing : ~dp.rx_framing;
    end
  end
endmodule
`default_nettype wire

// *** test/ucs_top_bench.sv ***
// Purpose: Self-checking bench for the serial port control registers.
// Assumes: Datapath requests pass through the datapath model one edge late.
// Notes:   Every scenario is its own task; checks go through chk.
`timescale 1ns/1ps
`default_nettype none
module ucs_top_bench;
  import ucs_pkg::*;
  logic            aclk;
  logic            aresetn;
  ucs_axi_req_type req;
  ucs_axi_rsp_type rsp;
  logic [7:0]      pdc;
  ucs_dp_type      cmd;
  ucs_dp_type      dp;
  ucs_ctrl_type    ctrl;
  logic [31:0]     rd;
  logic [1:0]      resp;
  logic [3:0]      strb = 4'hf;
  int              n;
  int              n_fail = 0;
  int              checked = 0;

  ucs_top ucs_top_inst (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .pin_direction_control(pdc), .dp(dp), .ctrl(ctrl));
  ucs_datapath_model ucs_datapath_model_inst (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
    .dp(dp));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d}, wstrb: strb,
             bready: 1'b1, default: '0};
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [7:0] a);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
    rdr(a);
    chk(rd === {24'h0, e} && resp === RESP_OKAY, m);
  endtask

  task automatic pulse(input logic done, input logic ninth, input logic framing_error_flag, input logic bufrd);
    cmd <= '{tsr_empty: 1'b1, rx_done: done, rx_ninth: ninth, rx_framing: framing_error_flag,
             rx_buffer_read: bufrd};
    @(posedge aclk);
    cmd <= '{tsr_empty: 1'b1, default: 1'b0};
    repeat (3) @(posedge aclk);
  endtask

  // Counts cycles between two ticks; 600 means no tick was seen.
  task automatic period;
    int i;
    for (i = 0; i < 600 && ctrl.baud_tick !== 1'b1; i++) @(posedge aclk);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (ctrl.baud_tick !== 1'b1 && n < 600);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(XMT_CTRL_STATUS_ADDR, 8'h02, "transmit reset");
    rchk(RCV_CTRL_STATUS_ADDR, 8'h00, "receive reset");
    rchk(BAUD_DIVISOR_ADDR, 8'h00, "divisor reset");
    chk(ctrl === '0, "ctrl reset");
    $display("test reset done");
  endtask

  task automatic t_modes;
    logic [7:0]   xv [4] = '{8'h00, 8'h90, 8'h10, 8'h80};
    ucs_mode_type em [4] = '{UCS_MODE_ASYNC, UCS_MODE_SYNC_MASTER, UCS_MODE_SYNC_SLAVE,
                             UCS_MODE_ASYNC};
    // The transmitter is only enabled while the port itself is enabled.
    wr(RCV_CTRL_STATUS_ADDR, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(XMT_CTRL_STATUS_ADDR, xv[i]);
      chk(ctrl.mode === em[i], "mode select");
    end
    wr(XMT_CTRL_STATUS_ADDR, 8'hff);
    rchk(XMT_CTRL_STATUS_ADDR, 8'hf7, "transmit readback");
    chk(ctrl.tx_nine === 1'b1 && ctrl.tx_ninth_data === 1'b1, "nine bits");
    wr(XMT_CTRL_STATUS_ADDR, 8'h20);
    chk(ctrl.tx_nine === 1'b0 && ctrl.tx_enable === 1'b1, "eight bits");
    cmd.tsr_empty <= 1'b0;
    repeat (3) @(posedge aclk);
    rchk(XMT_CTRL_STATUS_ADDR, 8'h20, "shift register full");
    cmd.tsr_empty <= 1'b1;
    $display("test modes done");
  endtask

  task automatic t_pins;
    logic [7:0] pv [3] = '{8'hc0, 8'h80, 8'h40};
    logic       ev [3] = '{1'b1, 1'b0, 1'b0};
    wr(RCV_CTRL_STATUS_ADDR, 8'h80);
    for (int i = 0; i < 3; i++) begin
      pdc <= pv[i];
      repeat (3) @(posedge aclk);
      chk(ctrl.pins_serial === ev[i], "pin directions");
    end
    pdc <= 8'hc0;
    wr(RCV_CTRL_STATUS_ADDR, 8'h00);
    chk(ctrl.pins_serial === 1'b0, "port disabled");
    $display("test pins done");
  endtask

  task automatic t_override;
    wr(XMT_CTRL_STATUS_ADDR, 8'h30);
    wr(RCV_CTRL_STATUS_ADDR, 8'h90);
    chk(ctrl.tx_enable === 1'b0, "continuous overrides transmit");
    wr(RCV_CTRL_STATUS_ADDR, 8'ha0);
    chk(ctrl.tx_enable === 1'b0, "single overrides transmit");
    wr(XMT_CTRL_STATUS_ADDR, 8'h20);
    chk(ctrl.tx_enable === 1'b1, "no override when async");
    $display("test override done");
  endtask

  task automatic t_rx;
    wr(RCV_CTRL_STATUS_ADDR, 8'hd0);
    chk(ctrl.rx_enable === 1'b1 && ctrl.rx_nine === 1'b1, "receive setup");
    pulse(1'b1, 1'b1, 1'b1, 1'b0);
    rchk(RCV_CTRL_STATUS_ADDR, 8'hd5, "framing and ninth");
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    rchk(RCV_CTRL_STATUS_ADDR, 8'hd7, "overrun");
    pulse(1'b0, 1'b0, 1'b0, 1'b1);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    rchk(RCV_CTRL_STATUS_ADDR, 8'hd2, "next byte");
    wr(RCV_CTRL_STATUS_ADDR, 8'hdf);
    rchk(RCV_CTRL_STATUS_ADDR, 8'hd2, "status writes");
    wr(RCV_CTRL_STATUS_ADDR, 8'hc0);
    rchk(RCV_CTRL_STATUS_ADDR, 8'hc0, "overrun cleared");
    pulse(1'b1, 1'b1, 1'b1, 1'b1);
    rchk(RCV_CTRL_STATUS_ADDR, 8'hc0, "receiver off");
    $display("test receive done");
  endtask

  task automatic t_single;
    wr(XMT_CTRL_STATUS_ADDR, 8'h90);
    wr(RCV_CTRL_STATUS_ADDR, 8'ha0);
    chk(ctrl.rx_enable === 1'b1, "single starts");
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    rchk(RCV_CTRL_STATUS_ADDR, 8'h80, "single clears");
    wr(RCV_CTRL_STATUS_ADDR, 8'hb0);
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    chk(ctrl.rx_enable === 1'b1, "continuous runs on");
    wr(RCV_CTRL_STATUS_ADDR, 8'ha0);
    wr(XMT_CTRL_STATUS_ADDR, 8'h10);
    chk(ctrl.rx_enable === 1'b0, "single ignored slave");
    wr(XMT_CTRL_STATUS_ADDR, 8'h00);
    chk(ctrl.rx_enable === 1'b0, "single ignored async");
    $display("test single done");
  endtask

  task automatic t_baud;
    wr(RCV_CTRL_STATUS_ADDR, 8'h80);
    wr(BAUD_DIVISOR_ADDR, 8'h02);
    wr(XMT_CTRL_STATUS_ADDR, 8'h04);
    period;
    chk(n == 48, "high speed period");
    wr(XMT_CTRL_STATUS_ADDR, 8'h00);
    period;
    chk(n == 192, "low speed period");
    wr(XMT_CTRL_STATUS_ADDR, 8'h94);
    period;
    chk(n == 12, "sync master period");
    wr(XMT_CTRL_STATUS_ADDR, 8'h14);
    period;
    chk(n == 600, "no tick in slave");
    $display("test baud done");
  endtask

  task automatic t_unmapped;
    wr(8'h40, 8'h55);
    chk(resp === RESP_SLVERR, "unmapped write");
    rdr(8'h40);
    chk(rd === 32'h0 && resp === RESP_SLVERR, "unmapped read");
    strb = 4'he;
    wr(XMT_CTRL_STATUS_ADDR, 8'h00);
    strb = 4'hf;
    chk(resp === RESP_OKAY, "lane zero off answers okay");
    rchk(XMT_CTRL_STATUS_ADDR, 8'h16, "lane zero off keeps value");
    $display("test unmapped done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    pdc = 8'hc0;
    cmd = '{tsr_empty: 1'b1, default: 1'b0};
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_modes;
    t_pins;
    t_override;
    t_rx;
    t_single;
    t_baud;
    t_unmapped;
    report_and_stop;
  end

  // The scenarios need well under 5000 cycles; this only catches a hang.
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule
`default_nettype wire
